// ---- hw/sbtc_pkg.sv ----
// Package of constants for the sixteen-bit timer/counter block.
package sbtc_pkg;
    localparam logic [7:0] OFF_CONTROL = 8'h10;
    localparam logic [7:0] OFF_COUNT_LOW = 8'h14;
    localparam logic [7:0] OFF_COUNT_HIGH = 8'h18;
    localparam logic [7:0] OFF_FLAGS = 8'h1C;
    localparam logic [7:0] OFF_ENABLES = 8'h20;
    localparam logic [7:0] OFF_PORT = 8'h24;
    localparam int BIT_RUN = 0;
    localparam int BIT_SRC = 1;
    localparam int BIT_SYNC = 2;
    localparam int BIT_OSC = 3;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_PS_HI = 5;
    localparam int BIT_OVF = 0;
    localparam logic [5:0] CONTROL_RESET = 6'h00;
    localparam logic [3:0] CCP_SPECIAL_EVENT = 4'hB;
    localparam int INSTR_DIV = 4;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [7:0] BYTE_MASK_LOW2 = 8'hFC;
endpackage

// ---- hw/sbtc_prescaler.sv ----
// Clock prescaler selecting divide by one, two, four or eight.
`timescale 1ns/1ps
module sbtc_prescaler (
    input wire logic clock,
    input wire logic rst,
    input wire logic clear,
    input wire logic tick,
    input wire logic [1:0] select,
    output logic pulse
);
    logic [2:0] count;

    // Ripple stage modelled as a counter of input ticks.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count <= 3'h0;
        end else if (clear) begin
            count <= 3'h0;
        end else if (tick) begin
            count <= count + 3'h1;
        end
    end

    // Pulse on the tick that completes a full prescale period.
    always_comb begin
        unique case (select)
            2'b00: pulse = tick;
            2'b01: pulse = tick && count[0];
            2'b10: pulse = tick && (count[1:0] == 2'h3);
            2'b11: pulse = tick && (count == 3'h7);
        endcase
    end
endmodule

// ---- hw/sbtc_edge_detect.sv ----
// Optional two-stage synchroniser with rising and falling edge detect.
`timescale 1ns/1ps
module sbtc_edge_detect (
    input wire logic clock,
    input wire logic rst,
    input wire logic pin,
    input wire logic bypass,
    output logic rise,
    output logic fall
);
    logic meta;
    logic stable;
    logic last;
    logic level;

    // The first stage feeds only the second, to contain metastability.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta <= 1'b0;
            stable <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= pin;
            stable <= meta;
            last <= level;
        end
    end

    // Bypass takes the pin as already in step with the clock.
    assign level = bypass ? pin : stable;
    assign rise = level && !last;
    assign fall = !level && last;
endmodule

// ---- hw/sbtc_top.sv ----
// Sixteen-bit timer/counter with APB register access.
`timescale 1ns/1ps
module sbtc_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_clock_pin,
    input wire logic osc_input_pin,
    input wire logic [1:0] port_pin_in,
    input wire logic [3:0] ccp1_mode,
    input wire logic ccp1_match,
    input wire logic [3:0] ccp2_mode,
    input wire logic ccp2_match,
    output logic [1:0] port_pin_oe,
    output logic osc_inverter_on,
    output logic overflow_irq
);
    logic run_enable;
    logic clock_source_select;
    logic sync_bypass;
    logic low_power_osc_enable;
    logic [1:0] prescale_select;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic overflow_flag;
    logic overflow_irq_enable;
    logic [1:0] port_direction_bits;
    logic [1:0] instr_phase;
    logic armed;
    logic ext_rise;
    logic ext_fall;
    logic sel_pin;
    logic raw_tick;
    logic inc;
    logic wrap;
    logic ccp_reset;
    logic wr;
    logic count_write;
    logic pre_clear;
    logic [15:0] sixteen_bit_count;
    logic [15:0] next_count;
    logic [1:0] port_read;

    assign sixteen_bit_count = {count_high_byte, count_low_byte};

    // Zero-wait APB slave: every access completes in its access phase.
    assign pready = 1'b1;
    assign wr = psel && penable && pwrite;
    assign count_write = wr && (paddr == sbtc_pkg::OFF_COUNT_LOW
        || paddr == sbtc_pkg::OFF_COUNT_HIGH);
    assign pslverr = psel && penable && !(paddr == sbtc_pkg::OFF_CONTROL
        || paddr == sbtc_pkg::OFF_COUNT_LOW
        || paddr == sbtc_pkg::OFF_COUNT_HIGH
        || paddr == sbtc_pkg::OFF_FLAGS
        || paddr == sbtc_pkg::OFF_ENABLES
        || paddr == sbtc_pkg::OFF_PORT);

    // Control fields; all clear at reset so the timer starts stopped.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            {prescale_select, low_power_osc_enable, sync_bypass,
                clock_source_select, run_enable} <= sbtc_pkg::CONTROL_RESET;
        end else if (wr && paddr == sbtc_pkg::OFF_CONTROL) begin
            run_enable <= pwdata[sbtc_pkg::BIT_RUN];
            clock_source_select <= pwdata[sbtc_pkg::BIT_SRC];
            sync_bypass <= pwdata[sbtc_pkg::BIT_SYNC];
            low_power_osc_enable <= pwdata[sbtc_pkg::BIT_OSC];
            prescale_select <= pwdata[sbtc_pkg::BIT_PS_HI:sbtc_pkg::BIT_PS_LO];
        end
    end

    // Interrupt enable and port direction bits.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            overflow_irq_enable <= 1'b0;
            port_direction_bits <= 2'h3;
        end else if (wr && paddr == sbtc_pkg::OFF_ENABLES) begin
            overflow_irq_enable <= pwdata[sbtc_pkg::BIT_OVF];
        end else if (wr && paddr == sbtc_pkg::OFF_PORT) begin
            port_direction_bits <= pwdata[1:0];
        end
    end

    // Instruction-cycle phase: one timer tick per four input clocks.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            instr_phase <= 2'h0;
        end else begin
            instr_phase <= instr_phase + 2'h1;
        end
    end

    // Oscillator input is used when the oscillator runs.
    assign sel_pin = low_power_osc_enable ? osc_input_pin
        : ext_clock_pin;

    // Synchroniser is bypassed only in counter mode.
    sbtc_edge_detect u_edge (
        .clock(clock),
        .rst(rst),
        .pin(sel_pin),
        .bypass(sync_bypass && clock_source_select),
        .rise(ext_rise),
        .fall(ext_fall)
    );

    // Counter mode waits for a falling edge after being enabled.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            armed <= 1'b0;
        end else if (!run_enable || !clock_source_select) begin
            armed <= 1'b0;
        end else if (ext_fall) begin
            armed <= 1'b1;
        end
    end

    // Raw tick from the selected source.
    assign raw_tick = run_enable && (clock_source_select
        ? (armed && ext_rise)
        : (instr_phase == 2'(sbtc_pkg::INSTR_DIV - 1)));

    // Prescaler restarts when stopped or when software rewrites the count.
    assign pre_clear = !run_enable || count_write;

    // Prescale then count; edges are synchronised, unless bypassed, before they reach the prescaler.
    sbtc_prescaler u_pre (
        .clock(clock),
        .rst(rst),
        .clear(pre_clear),
        .tick(raw_tick),
        .select(prescale_select),
        .pulse(inc)
    );

    // Special event trigger from either compare unit.
    assign ccp_reset = (ccp1_match && ccp1_mode == sbtc_pkg::CCP_SPECIAL_EVENT)
        || (ccp2_match && ccp2_mode == sbtc_pkg::CCP_SPECIAL_EVENT);
    assign wrap = inc && sixteen_bit_count == sbtc_pkg::COUNT_MAX;
    assign next_count = sixteen_bit_count + 16'h0001;

    // Count update; software writes win over an increment to avoid tearing.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_low_byte <= 8'h00;
            count_high_byte <= 8'h00;
        end else if (ccp_reset) begin
            count_low_byte <= 8'h00;
            count_high_byte <= 8'h00;
        end else if (wr && paddr == sbtc_pkg::OFF_COUNT_LOW) begin
            count_low_byte <= pwdata[7:0];
        end else if (wr && paddr == sbtc_pkg::OFF_COUNT_HIGH) begin
            count_high_byte <= pwdata[7:0];
        end else if (inc) begin
            {count_high_byte, count_low_byte} <= next_count;
        end
    end

    // Sticky overflow flag; a set in the clearing cycle wins.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            overflow_flag <= 1'b0;
        end else if (wrap) begin
            overflow_flag <= 1'b1;
        end else if (wr && paddr == sbtc_pkg::OFF_FLAGS) begin
            overflow_flag <= pwdata[sbtc_pkg::BIT_OVF];
        end
    end

    assign overflow_irq = overflow_flag && overflow_irq_enable;
    assign osc_inverter_on = low_power_osc_enable;
    // Oscillator forces both pins to inputs, reading zero.
    assign port_pin_oe = low_power_osc_enable ? 2'h0
        : ~port_direction_bits;
    assign port_read = low_power_osc_enable ? 2'h0 : port_pin_in;

    // Read data is registered on the setup-phase edge, ahead of the access phase.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                sbtc_pkg::OFF_CONTROL: prdata <= {26'h0, prescale_select,
                    low_power_osc_enable, sync_bypass, clock_source_select,
                    run_enable};
                sbtc_pkg::OFF_COUNT_LOW: prdata <= {24'h0, count_low_byte};
                sbtc_pkg::OFF_COUNT_HIGH: prdata <= {24'h0, count_high_byte};
                sbtc_pkg::OFF_FLAGS: prdata <= {31'h0, overflow_flag};
                sbtc_pkg::OFF_ENABLES: prdata <= {31'h0, overflow_irq_enable};
                sbtc_pkg::OFF_PORT: prdata <= {28'h0, port_read,
                    port_direction_bits};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    sequence s_wrap;
        inc && sixteen_bit_count == 16'hFFFF;
    endsequence

    AST_WRAP_ZERO: assert property (@(posedge clock) disable iff (rst)
        (s_wrap and (!ccp_reset && !wr)) |=> sixteen_bit_count == 16'h0000)
        else $error("Count did not wrap to zero.");
    AST_FLAG_SET: assert property (@(posedge clock) disable iff (rst)
        s_wrap |=> overflow_flag)
        else $error("Overflow flag not set on wrap.");
    AST_IRQ_GATE: assert property (@(posedge clock) disable iff (rst)
        overflow_irq == (overflow_flag && overflow_irq_enable))
        else $error("Interrupt not gated by enable.");
    AST_STOPPED: assert property (@(posedge clock) disable iff (rst)
        !run_enable && !ccp_reset && !wr |=> $stable(sixteen_bit_count))
        else $error("Count moved while stopped.");
    AST_CCP_CLEAR: assert property (@(posedge clock) disable iff (rst)
        ccp_reset |=> sixteen_bit_count == 16'h0000)
        else $error("Trigger did not clear count.");
    AST_PIN_INPUT: assert property (@(posedge clock) disable iff (rst)
        low_power_osc_enable |-> port_pin_oe == 2'h0)
        else $error("Pins driven with oscillator on.");
    AST_ARM: assert property (@(posedge clock) disable iff (rst)
        clock_source_select && !armed |-> !raw_tick)
        else $error("Counted before falling edge.");
    AST_TIMER_RATE: assert property (@(posedge clock) disable iff (rst)
        raw_tick && !clock_source_select |=> !raw_tick [*3])
        else $error("Timer ticks faster than one in four.");
    AST_FLAG_HOLD: assert property (@(posedge clock) disable iff (rst)
        overflow_flag && !wr |=> overflow_flag)
        else $error("Flag dropped without clear.");

    // Divide checker: ticks that gave no pulse since the previous pulse.
    // It restarts on any control write, as a new ratio may begin mid-period.
    logic control_write;
    logic [3:0] idle_ticks;
    logic pulse_seen;
    assign control_write = wr && paddr == sbtc_pkg::OFF_CONTROL;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            idle_ticks <= 4'h0;
            pulse_seen <= 1'b0;
        end else if (pre_clear || control_write) begin
            idle_ticks <= 4'h0;
            pulse_seen <= 1'b0;
        end else if (inc) begin
            idle_ticks <= 4'h0;
            pulse_seen <= 1'b1;
        end else if (raw_tick) begin
            idle_ticks <= idle_ticks + 4'h1;
        end
    end

    // A plain increment, with no trigger, write or wrap in the same cycle.
    sequence s_step;
        inc && sixteen_bit_count != 16'hFFFF && !ccp_reset && !count_write;
    endsequence

    // A falling edge while counting is enabled and left unchanged.
    sequence s_fall_seen;
        clock_source_select && run_enable && ext_fall && !control_write;
    endsequence

    AST_STEP: assert property (@(posedge clock) disable iff (rst)
        s_step |=> sixteen_bit_count == $past(sixteen_bit_count) + 16'h0001)
        else $error("Count did not step by one.");
    AST_ARM_SET: assert property (@(posedge clock) disable iff (rst)
        s_fall_seen |=> armed)
        else $error("Falling edge did not arm the counter.");
    AST_EDGE_INC: assert property (@(posedge clock) disable iff (rst)
        clock_source_select && run_enable && armed && ext_rise |-> raw_tick)
        else $error("Rising edge not counted.");

    // Timer mode ignores the bypass bit: the tick rate stays fixed.
    AST_TIMER_PH: assert property (@(posedge clock)
        disable iff (rst) !clock_source_select && run_enable
        |-> raw_tick == (instr_phase == 2'(sbtc_pkg::INSTR_DIV - 1)))
        else $error("Timer tick not once per instruction cycle.");

    // Prescaler: no invented pulses, and the selected ratio between pulses.
    AST_DIV_ONE: assert property (@(posedge clock) disable iff (rst)
        prescale_select == 2'b00 |-> inc == raw_tick)
        else $error("Divide by one dropped a tick.");
    AST_NO_EXTRA: assert property (@(posedge clock) disable iff (rst)
        inc |-> raw_tick)
        else $error("Prescaler pulsed without a tick.");
    AST_RATIO: assert property (@(posedge clock) disable iff (rst)
        inc && pulse_seen
        |-> idle_ticks == (4'h1 << prescale_select) - 4'h1)
        else $error("Prescaler divide ratio wrong.");
    AST_STOP_INC: assert property (@(posedge clock) disable iff (rst)
        !run_enable |-> !inc)
        else $error("Prescaler pulsed while stopped.");

    // Software writes land in the addressed byte unless a trigger wins.
    AST_WR_LOW: assert property (@(posedge clock) disable iff (rst)
        wr && paddr == sbtc_pkg::OFF_COUNT_LOW && !ccp_reset
        |=> count_low_byte == $past(pwdata[7:0]))
        else $error("Low byte write lost.");
    AST_WR_HIGH: assert property (@(posedge clock) disable iff (rst)
        wr && paddr == sbtc_pkg::OFF_COUNT_HIGH && !ccp_reset
        |=> count_high_byte == $past(pwdata[7:0]))
        else $error("High byte write lost.");

    // Read data checks on what software sees, then pin select, second-unit trigger and flag clear checks.
    AST_CTRL_RD: assert property (@(posedge clock) disable iff (rst)
        psel && !penable && !pwrite && paddr == sbtc_pkg::OFF_CONTROL
        |=> prdata[31:6] == 26'h0)
        else $error("Unused control bits read nonzero.");
    AST_PORT_RD: assert property (@(posedge clock) disable iff (rst)
        psel && !penable && !pwrite && paddr == sbtc_pkg::OFF_PORT
        && low_power_osc_enable |=> prdata[3:2] == 2'b00)
        else $error("Pins read nonzero with oscillator on.");
    AST_SRC_PIN: assert property (@(posedge clock) disable iff (rst)
        clock_source_select |-> sel_pin == (low_power_osc_enable
            ? osc_input_pin : ext_clock_pin))
        else $error("Wrong pin feeds the counter.");
    AST_TRIGGER: assert property (@(posedge clock) disable iff (rst)
        ccp2_match && ccp2_mode == sbtc_pkg::CCP_SPECIAL_EVENT
        |=> sixteen_bit_count == 16'h0000)
        else $error("Second unit trigger did not clear count.");
    AST_FLAG_CLR: assert property (@(posedge clock) disable iff (rst)
        wr && paddr == sbtc_pkg::OFF_FLAGS && !pwdata[sbtc_pkg::BIT_OVF]
        && !wrap |=> !overflow_flag)
        else $error("Flag not cleared by software.");

    // Reset must leave the timer stopped with every control field clear.
    AST_RESET_STOP: assert property (@(posedge clock) rst
        |=> !run_enable && !clock_source_select && !sync_bypass
        && !low_power_osc_enable && prescale_select == 2'b00)
        else $error("Control not cleared by reset.");
endmodule

// ---- verif/sbtc_clock_source.sv ----
// Model of the external clock source and crystal at the count pins.
`timescale 1ns/1ps
module sbtc_clock_source (
    input wire logic clock,
    output logic ext_clock_pin,
    output logic osc_input_pin
);
    // Both pins stand low between bursts; the source never runs free.
    initial begin
        ext_clock_pin = 1'b0;
        osc_input_pin = 1'b0;
    end

    // Sends n pulses, four clocks low then four high, on one pin.
    task automatic send(input logic osc, input int n);
        for (int i = 0; i < n; i++) begin
            repeat (4) @(posedge clock);
            if (osc) osc_input_pin <= 1'b1;
            else ext_clock_pin <= 1'b1;
            repeat (4) @(posedge clock);
            if (osc) osc_input_pin <= 1'b0;
            else ext_clock_pin <= 1'b0;
        end
    endtask
endmodule

// ---- verif/test_sixteen_bit_timer_counter.sv ----
// Self-checking testbench for the sixteen-bit timer/counter.
`timescale 1ns/1ps
module test_sixteen_bit_timer_counter;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [1:0] port_pin_in = 2'b11;
    logic [3:0] ccp1_mode = 4'h0;
    logic [3:0] ccp2_mode = 4'h0;
    logic ccp1_match = 1'b0;
    logic ccp2_match = 1'b0;
    logic ext_clock_pin;
    logic osc_input_pin;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] port_pin_oe;
    logic osc_inverter_on;
    logic overflow_irq;
    logic [31:0] q;
    logic e;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;

    sbtc_top dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_clock_pin(ext_clock_pin),
        .osc_input_pin(osc_input_pin), .port_pin_in(port_pin_in),
        .ccp1_mode(ccp1_mode), .ccp1_match(ccp1_match),
        .ccp2_mode(ccp2_mode), .ccp2_match(ccp2_match),
        .port_pin_oe(port_pin_oe), .osc_inverter_on(osc_inverter_on),
        .overflow_irq(overflow_irq));
    sbtc_clock_source part (.clock(clock), .ext_clock_pin(ext_clock_pin),
        .osc_input_pin(osc_input_pin));

    // The clock runs at 100 MHz.
    initial begin
        forever #5 clock = ~clock;
    end

    // A hung wait is cut short well beyond the few thousand cycles needed.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp,
        input logic [31:0] seen);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Free-running tick phase makes a timed count land one either side.
    task automatic near(input string name, input logic [31:0] exp,
        input logic [31:0] seen);
        if (seen === exp + 1 || seen === exp - 1) check(name, seen, seen);
        else check(name, exp, seen);
    endtask

    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic err);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd16(output logic [15:0] v);
        logic [31:0] h;
        apb(1'b0, sbtc_pkg::OFF_COUNT_HIGH, 32'h0, h, e);
        apb(1'b0, sbtc_pkg::OFF_COUNT_LOW, 32'h0, q, e);
        v = {h[7:0], q[7:0]};
    endtask

    task automatic t_reset_regs;
        logic [15:0] v;
        apb(1'b0, sbtc_pkg::OFF_CONTROL, 32'h0, q, e);
        check("control reset", 32'h0, q);
        rd16(v);
        check("count reset", 32'h0, v);
        check("irq reset", 32'h0, overflow_irq);
        wr(sbtc_pkg::OFF_COUNT_HIGH, 32'hA5);
        wr(sbtc_pkg::OFF_COUNT_LOW, 32'h5A);
        rd16(v);
        check("count bytes", 32'hA55A, v);
        wr(sbtc_pkg::OFF_CONTROL, 32'hF0);
        apb(1'b0, sbtc_pkg::OFF_CONTROL, 32'h0, q, e);
        check("control upper bits", 32'h30, q);
        wr(sbtc_pkg::OFF_PORT, 32'h0);
        @(negedge clock);
        check("pin drive", 32'h3, port_pin_oe);
        apb(1'b1, 8'h40, 32'h1, q, e);
        check("unmapped write error", 32'h1, e);
        apb(1'b0, 8'h40, 32'h0, q, e);
        check("unmapped read", 32'h0, q);
    endtask

    task automatic t_timer;
        logic [7:0] ctl [4] = '{8'h01, 8'h15, 8'h21, 8'h31};
        logic [15:0] v;
        logic [15:0] w;
        for (int i = 0; i < 4; i++) begin
            wr(sbtc_pkg::OFF_COUNT_LOW, 32'h0);
            wr(sbtc_pkg::OFF_COUNT_HIGH, 32'h0);
            wr(sbtc_pkg::OFF_CONTROL, ctl[i]);
            repeat (480) @(posedge clock);
            wr(sbtc_pkg::OFF_CONTROL, 32'h0);
            rd16(v);
            near("timer count", 120 >> i, v);
        end
        repeat (40) @(posedge clock);
        rd16(w);
        check("stopped count", v, w);
    endtask

    task automatic t_overflow;
        logic [15:0] v;
        wr(sbtc_pkg::OFF_COUNT_LOW, 32'hFE);
        wr(sbtc_pkg::OFF_COUNT_HIGH, 32'hFF);
        wr(sbtc_pkg::OFF_CONTROL, 32'h01);
        repeat (20) @(posedge clock);
        wr(sbtc_pkg::OFF_CONTROL, 32'h0);
        rd16(v);
        near("wrapped count", 32'h4, v);
        apb(1'b0, sbtc_pkg::OFF_FLAGS, 32'h0, q, e);
        check("overflow flag", 32'h1, q);
        check("masked irq", 32'h0, overflow_irq);
        wr(sbtc_pkg::OFF_ENABLES, 32'h1);
        @(negedge clock);
        check("enabled irq", 32'h1, overflow_irq);
        wr(sbtc_pkg::OFF_FLAGS, 32'h0);
        @(negedge clock);
        check("cleared irq", 32'h0, overflow_irq);
        wr(sbtc_pkg::OFF_ENABLES, 32'h0);
    endtask

    task automatic t_counter;
        logic [7:0] ctl [3] = '{8'h03, 8'h07, 8'h0B};
        logic [15:0] v;
        logic osc;
        for (int i = 0; i < 3; i++) begin
            osc = ctl[i][3];
            wr(sbtc_pkg::OFF_COUNT_LOW, 32'h0);
            wr(sbtc_pkg::OFF_COUNT_HIGH, 32'h0);
            wr(sbtc_pkg::OFF_CONTROL, ctl[i]);
            @(negedge clock);
            check("inverter", osc, osc_inverter_on);
            check("pin drive", osc ? 2'b00 : 2'b11, port_pin_oe);
            apb(1'b0, sbtc_pkg::OFF_PORT, 32'h0, q, e);
            check("port read", osc ? 32'h0 : 32'hC, q);
            part.send(!osc, 3);
            part.send(osc, 6);
            repeat (8) @(posedge clock);
            wr(sbtc_pkg::OFF_CONTROL, 32'h0);
            rd16(v);
            check("edge count", 32'h5, v);
        end
    endtask

    task automatic t_ccp;
        logic [15:0] v;
        for (int i = 0; i < 3; i++) begin
            wr(sbtc_pkg::OFF_COUNT_LOW, 32'h34);
            wr(sbtc_pkg::OFF_COUNT_HIGH, 32'h12);
            @(posedge clock);
            ccp1_mode <= (i == 0) ? 4'hA : 4'hB;
            ccp1_match <= (i < 2);
            ccp2_mode <= 4'hB;
            ccp2_match <= (i == 2);
            @(posedge clock);
            ccp1_match <= 1'b0;
            ccp2_match <= 1'b0;
            rd16(v);
            check("trigger reset", (i == 0) ? 32'h1234 : 32'h0, v);
        end
    endtask

    // Reset for ten cycles, then each scenario in turn.
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        t_reset_regs();
        $display("test registers done");
        t_timer();
        $display("test timer done");
        t_overflow();
        $display("test overflow done");
        t_counter();
        $display("test counter done");
        t_ccp();
        $display("test trigger done");
        print_verdict();
    end
endmodule
